// *** hdl/rtcps_async_stage.sv ***
// First divider stage: wraps after divider value plus one kernel ticks
`timescale 1ns/1ps
`default_nettype none
module rtcps_async_stage #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Kernel tick and setting
  input wire logic kernel_tick,
  input wire logic [WIDTH-1:0] divider,
  // Stage output
  output logic stage_tick,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_q;

  initial begin
    if (WIDTH < 1) $error("rtcps_async_stage: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (kernel_tick) begin
      if (count_q == '0) begin
        count_q <= divider;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  assign stage_tick = kernel_tick && (count_q == '0);
  assign count = count_q;
endmodule
`default_nettype wire

// *** hdl/rtcps_pkg.sv ***
// Shared constants for the calendar prescaler chain
`default_nettype none
package rtcps_pkg;
  localparam int ASYNC_W = 7;
  localparam int SYNC_W = 15;
  localparam int ADDR_W = 4;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] PRER_OFS = 4'h4;
  localparam logic [3:0] SUBSEC_OFS = 4'h8;
  localparam logic [3:0] SECONDS_OFS = 4'hc;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int PRER_SYNC_LSB = 0;
  localparam int PRER_ASYNC_LSB = 16;
  // Values after reset
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [ASYNC_W-1:0] ASYNC_DIV_RST = 7'h7f;
  localparam logic [SYNC_W-1:0] SYNC_DIV_RST = 15'h00ff;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SRC_EXT_LOW_XTAL,
    SRC_INT_LOW_OSC,
    SRC_EXT_HIGH_CLK
  } rtcps_src_t;
  localparam rtcps_src_t SEL_RST = SRC_EXT_LOW_XTAL;
endpackage
`default_nettype wire

// *** hdl/rtcps_subsec_stage.sv ***
// Second divider stage: subsecond downcounter with reload
`timescale 1ns/1ps
`default_nettype none
module rtcps_subsec_stage #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // First-stage tick and setting
  input wire logic async_tick,
  input wire logic [WIDTH-1:0] divider,
  // Outputs
  output logic calendar_tick,
  output logic [WIDTH-1:0] subsecond
);
  logic [WIDTH-1:0] ssr_q;

  initial begin
    if (WIDTH < 1) $error("rtcps_subsec_stage: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ssr_q <= '0;
    end else if (async_tick) begin
      if (ssr_q == '0) begin
        ssr_q <= divider;
      end else begin
        ssr_q <= ssr_q - 1'b1;
      end
    end
  end

  assign calendar_tick = async_tick && (ssr_q == '0);
  assign subsecond = ssr_q;
endmodule
`default_nettype wire

// *** hdl/rtcps_top.sv ***
// Calendar prescaler chain with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module rtcps_top #(
  parameter int ASYNC_W = rtcps_pkg::ASYNC_W,
  parameter int SYNC_W = rtcps_pkg::SYNC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Kernel clock sources, sampled as levels
  input wire logic external_low_speed_crystal,
  input wire logic internal_low_speed_oscillator,
  input wire logic external_high_speed_clock,
  // AXI4-Lite write address
  input wire logic [rtcps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [rtcps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Prescaler outputs
  output logic async_stage_clock,
  output logic calendar_tick_clock,
  output logic [31:0] seconds_count
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The register layout holds at most 7 and 15 bits; the 2^22 ceiling follows
  initial begin
    if (ASYNC_W < 1 || ASYNC_W > 7) $error("rtcps_top: ASYNC_W out of range");
    if (SYNC_W < 1 || SYNC_W > 15) $error("rtcps_top: SYNC_W out of range");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic enable_q;
  rtcps_pkg::rtcps_src_t source_sel_q;
  logic [ASYNC_W-1:0] async_divider_value;
  logic [SYNC_W-1:0] sync_divider_value;
  logic [31:0] seconds_q;
  logic [31:0] ctrl_word;
  logic [31:0] prer_word;

  // ----------------------------------------------------------------
  // Kernel clock selection
  // ----------------------------------------------------------------
  logic [2:0] src_in;
  logic [2:0] src_prev_q;
  logic [2:0] src_rise;
  logic rtc_kernel_clock;

  assign src_in = {external_high_speed_clock, internal_low_speed_oscillator,
                   external_low_speed_crystal};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_prev_q <= 3'h0;
    end else begin
      src_prev_q <= src_in;
    end
  end

  assign src_rise = src_in & ~src_prev_q;

  // One kernel tick per rising edge of the chosen source
  always_comb begin
    rtc_kernel_clock = 1'b0;
    unique case (source_sel_q)
      rtcps_pkg::SRC_EXT_LOW_XTAL: rtc_kernel_clock = enable_q && src_rise[0];
      rtcps_pkg::SRC_INT_LOW_OSC: rtc_kernel_clock = enable_q && src_rise[1];
      rtcps_pkg::SRC_EXT_HIGH_CLK: rtc_kernel_clock = enable_q && src_rise[2];
      default: rtc_kernel_clock = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  logic [ASYNC_W-1:0] async_count;
  logic [SYNC_W-1:0] subsecond_downcounter;

  // Work is pushed into the first stage so the wide counter toggles rarely
  rtcps_async_stage #(
    .WIDTH(ASYNC_W)
  ) u_async (
    .clk(clk),
    .rst_n(rst_n),
    .kernel_tick(rtc_kernel_clock),
    .divider(async_divider_value),
    .stage_tick(async_stage_clock),
    .count(async_count)
  );

  rtcps_subsec_stage #(
    .WIDTH(SYNC_W)
  ) u_subsec (
    .clk(clk),
    .rst_n(rst_n),
    .async_tick(async_stage_clock),
    .divider(sync_divider_value),
    .calendar_tick(calendar_tick_clock),
    .subsecond(subsecond_downcounter)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seconds_q <= 32'h0;
    end else if (calendar_tick_clock) begin
      seconds_q <= seconds_q + 32'h1;
    end
  end
  assign seconds_count = seconds_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [rtcps_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic [31:0] wmask;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= rtcps_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == rtcps_pkg::CTRL_OFS || awaddr_q == rtcps_pkg::PRER_OFS) ?
                 rtcps_pkg::RESP_OKAY : rtcps_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Divider settings take effect at the next counter wrap; enable and source select change at once
  logic [31:0] ctrl_new;
  logic [31:0] prer_new;
  assign ctrl_new = (ctrl_word & ~wmask) | (wdata_q & wmask);
  assign prer_new = (prer_word & ~wmask) | (wdata_q & wmask);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q <= rtcps_pkg::CTRL_EN_RST;
      source_sel_q <= rtcps_pkg::SEL_RST;
    end else if (do_write && awaddr_q == rtcps_pkg::CTRL_OFS) begin
      enable_q <= ctrl_new[rtcps_pkg::CTRL_EN_BIT];
      // An unused source code keeps the previous selection
      if (ctrl_new[rtcps_pkg::CTRL_SEL_LSB +: 2] != 2'h3) begin
        source_sel_q <= rtcps_pkg::rtcps_src_t'(ctrl_new[rtcps_pkg::CTRL_SEL_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      async_divider_value <= rtcps_pkg::ASYNC_DIV_RST[ASYNC_W-1:0];
      sync_divider_value <= rtcps_pkg::SYNC_DIV_RST[SYNC_W-1:0];
    end else if (do_write && awaddr_q == rtcps_pkg::PRER_OFS) begin
      async_divider_value <= prer_new[rtcps_pkg::PRER_ASYNC_LSB +: ASYNC_W];
      sync_divider_value <= prer_new[rtcps_pkg::PRER_SYNC_LSB +: SYNC_W];
    end
  end
  assign ctrl_word = {29'h0, source_sel_q, enable_q};
  assign prer_word = {{(16-ASYNC_W){1'b0}}, async_divider_value,
                      {(16-SYNC_W){1'b0}}, sync_divider_value};

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= rtcps_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= rtcps_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rtcps_pkg::CTRL_OFS: rdata_q <= ctrl_word;
        rtcps_pkg::PRER_OFS: rdata_q <= prer_word;
        rtcps_pkg::SUBSEC_OFS: rdata_q <= {{(32-SYNC_W){1'b0}}, subsecond_downcounter};
        rtcps_pkg::SECONDS_OFS: rdata_q <= seconds_q;
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= rtcps_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_kernel_source;
    @(posedge clk) disable iff (!rst_n)
    rtc_kernel_clock |-> enable_q && src_rise[source_sel_q];
  endproperty
  a_kernel_source: assert property (p_kernel_source)
    else $error("kernel tick without selected source edge");

  property p_async_tick_at_zero;
    @(posedge clk) disable iff (!rst_n)
    async_stage_clock |-> rtc_kernel_clock && async_count == '0;
  endproperty
  a_async_tick_at_zero: assert property (p_async_tick_at_zero)
    else $error("first stage tick away from wrap");

  property p_async_reload;
    @(posedge clk) disable iff (!rst_n)
    async_stage_clock |=> async_count == $past(async_divider_value);
  endproperty
  a_async_reload: assert property (p_async_reload)
    else $error("first stage did not reload divider value");

  property p_async_hold;
    @(posedge clk) disable iff (!rst_n)
    !rtc_kernel_clock |=> $stable(async_count);
  endproperty
  a_async_hold: assert property (p_async_hold)
    else $error("first stage moved without kernel tick");

  property p_subsec_dec;
    @(posedge clk) disable iff (!rst_n)
    async_stage_clock && subsecond_downcounter != '0 |=>
      subsecond_downcounter == $past(subsecond_downcounter) - 1'b1;
  endproperty
  a_subsec_dec: assert property (p_subsec_dec)
    else $error("subsecond downcounter did not decrement");

  property p_subsec_reload;
    @(posedge clk) disable iff (!rst_n)
    async_stage_clock && subsecond_downcounter == '0 |->
      calendar_tick_clock ##1 subsecond_downcounter == $past(sync_divider_value);
  endproperty
  a_subsec_reload: assert property (p_subsec_reload)
    else $error("subsecond reload or calendar tick missing");

  property p_subsec_hold;
    @(posedge clk) disable iff (!rst_n)
    !async_stage_clock |=> $stable(subsecond_downcounter);
  endproperty
  a_subsec_hold: assert property (p_subsec_hold)
    else $error("subsecond counter moved without first stage tick");

  property p_seconds_advance;
    @(posedge clk) disable iff (!rst_n)
    calendar_tick_clock |=> seconds_q == $past(seconds_q) + 32'h1;
  endproperty
  a_seconds_advance: assert property (p_seconds_advance)
    else $error("calendar count did not advance");

  property p_cal_needs_async;
    @(posedge clk) disable iff (!rst_n)
    calendar_tick_clock |-> async_stage_clock && rtc_kernel_clock;
  endproperty
  a_cal_needs_async: assert property (p_cal_needs_async)
    else $error("calendar tick without both stages wrapping");
endmodule
`default_nettype wire

// *** verification/test_rtc_clock_prescaler_chain.sv ***
// Self-checking bench for the calendar prescaler chain
`timescale 1ns/1ps
`default_nettype none
module test_rtc_clock_prescaler_chain;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] src_lvl = 3'h0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] wr_strb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic async_pulse;
  logic cal_pulse;
  logic [31:0] secs;
  int num_errors = 0;
  int compares = 0;
  int n_async = 0;
  int n_cal = 0;
  int ma, ms, ea, ec;
  int cfg_a[5] = '{1, 0, 2, 127, 4};
  int cfg_s[5] = '{1, 0, 3, 1, 0};
  int cfg_src[5] = '{0, 1, 2, 0, 1};
  int cfg_n[5] = '{12, 5, 30, 260, 11};
  logic [31:0] rd;
  logic [1:0] rsp;

  always #5 clk = ~clk;

  rtcps_top uut (
    .clk(clk), .rst_n(rst_n),
    .external_low_speed_crystal(src_lvl[0]),
    .internal_low_speed_oscillator(src_lvl[1]),
    .external_high_speed_clock(src_lvl[2]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .async_stage_clock(async_pulse), .calendar_tick_clock(cal_pulse), .seconds_count(secs)
  );

  // Pulses are combinational, so count them at the edge that closes their cycle
  always @(posedge clk) begin
    if (rst_n === 1'b1 && async_pulse === 1'b1) n_async++;
    if (rst_n === 1'b1 && cal_pulse === 1'b1) n_cal++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Handshakes are judged at the rising edge; one edge passes before each new request
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wr_strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      n++;
      if (n > 200) begin
        num_errors++;
        close_out();
      end
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      n++;
      if (n > 200) begin
        num_errors++;
        close_out();
      end
    end while (!(rvalid === 1'b1 && rready === 1'b1));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // One rising edge on a source, held two cycles each way, one more than the sampler needs
  task automatic kick(input int s);
    src_lvl[s] <= 1'b1;
    repeat (2) @(posedge clk);
    src_lvl[s] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Reference: first stage wraps after a+1 ticks, subsecond reloads after reaching zero
  task automatic model_tick(input int a, input int s);
    if (ma == 0) begin
      ma = a;
      ea++;
      if (ms == 0) begin
        ms = s;
        ec++;
      end else begin
        ms--;
      end
    end else begin
      ma--;
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_rd(rtcps_pkg::CTRL_OFS, rd, rsp);
    check(rd, 32'h1, "ctrl reset");
    axi_rd(rtcps_pkg::PRER_OFS, rd, rsp);
    check(rd, 32'h007f00ff, "divider reset");
    axi_rd(rtcps_pkg::SUBSEC_OFS, rd, rsp);
    check(rd, 32'h0, "subsecond reset");
    check({30'h0, rsp}, {30'h0, rtcps_pkg::RESP_OKAY}, "read resp");
    axi_wr(rtcps_pkg::SUBSEC_OFS, 32'h5, rsp);
    check({30'h0, rsp}, {30'h0, rtcps_pkg::RESP_SLVERR}, "ro write resp");
    axi_wr(rtcps_pkg::SECONDS_OFS, 32'h5, rsp);
    check({30'h0, rsp}, {30'h0, rtcps_pkg::RESP_SLVERR}, "ro write resp");
    // Code 3 is unused and must leave the selection alone
    axi_wr(rtcps_pkg::CTRL_OFS, 32'h7, rsp);
    axi_rd(rtcps_pkg::CTRL_OFS, rd, rsp);
    check(rd, 32'h1, "unused source code");
    wr_strb = 4'h4;
    axi_wr(rtcps_pkg::PRER_OFS, 32'h00550000, rsp);
    wr_strb = 4'hf;
    axi_rd(rtcps_pkg::PRER_OFS, rd, rsp);
    check(rd, 32'h005500ff, "byte lane write");
    axi_wr(rtcps_pkg::PRER_OFS, 32'h007f00ff, rsp);
    axi_rd(rtcps_pkg::PRER_OFS, rd, rsp);
    check(rd, 32'h007f00ff, "crystal setting");
    for (int c = 0; c < 5; c++) begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      n_async = 0;
      n_cal = 0;
      ma = 0;
      ms = 0;
      ea = 0;
      ec = 0;
      axi_wr(rtcps_pkg::CTRL_OFS, 32'(cfg_src[c] * 2 + 1), rsp);
      check({30'h0, rsp}, 32'h0, "ctrl write resp");
      axi_wr(rtcps_pkg::PRER_OFS, 32'((cfg_a[c] << 16) | cfg_s[c]), rsp);
      axi_rd(rtcps_pkg::PRER_OFS, rd, rsp);
      check(rd, 32'((cfg_a[c] << 16) | cfg_s[c]), "divider readback");
      for (int k = 0; k < cfg_n[c]; k++) begin
        kick(cfg_src[c]);
        model_tick(cfg_a[c], cfg_s[c]);
      end
      check(32'(n_async), 32'(ea), "first stage pulses");
      check(32'(n_cal), 32'(ec), "calendar pulses");
      check(secs, 32'(ec), "seconds count");
      axi_rd(rtcps_pkg::SUBSEC_OFS, rd, rsp);
      check(rd, 32'(ms), "subsecond value");
      axi_rd(rtcps_pkg::SECONDS_OFS, rd, rsp);
      check(rd, 32'(ec), "seconds register");
      // Edges on the two unselected sources must not move anything
      for (int k = 0; k < 3; k++) begin
        kick((cfg_src[c] + 1) % 3);
        kick((cfg_src[c] + 2) % 3);
      end
      check(32'(n_async), 32'(ea), "unselected sources ignored");
      axi_wr(rtcps_pkg::CTRL_OFS, 32'(cfg_src[c] * 2), rsp);
      repeat (3) kick(cfg_src[c]);
      check(32'(n_async), 32'(ea), "disabled chain frozen");
      axi_rd(rtcps_pkg::SUBSEC_OFS, rd, rsp);
      check(rd, 32'(ms), "subsecond frozen");
    end
    close_out();
  end

  // Whole run is under two thousand cycles; allow a wide margin
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
